// [hep_defines.svh]
// constants for the host emulation port: pin layout, fields, offsets, reset values
`ifndef HEP_DEFINES_SVH
`define HEP_DEFINES_SVH

`define HEP_ADDR_W 3
`define HEP_DATA_W 8
`define HEP_ENTRY_W 12
`define HEP_FIFO_DEPTH 64
`define HEP_LEVEL_W 7

// synchronised host pin vector layout
`define HEP_PIN_W 15
`define HEP_PIN_FM_SEL 14
`define HEP_PIN_UART_SEL 13
`define HEP_PIN_WR 12
`define HEP_PIN_RD 11
`define HEP_PIN_ADDR_HI 10
`define HEP_PIN_ADDR_LO 8
`define HEP_PIN_DATA_HI 7
`define HEP_PIN_DATA_LO 0
`define HEP_PIN_IDLE 15'h7800

// fifo entry layout
`define HEP_ENT_SET_BIT 11
`define HEP_ENT_ADDR_HI 10
`define HEP_ENT_ADDR_LO 8
`define HEP_ENT_DATA_HI 7
`define HEP_ENT_DATA_LO 0

// host read offsets
`define HEP_FM_READBACK_OFS 3'h0
`define HEP_MIDI_READBACK_DATA_OFS 3'h0
`define HEP_MIDI_PORT_STATUS_OFS 3'h1

// status layout
`define HEP_STAT_WAIT_BIT 7
`define HEP_STAT_FULL_BIT 6
`define HEP_STAT_UNUSED 6'h00
`define HEP_UNDEF_READ 8'h00

// reset values
`define HEP_DATA_RESET 8'h00
`define HEP_ENTRY_RESET 12'h000

`endif

// [hep_pkg.sv]
// types shared by the host emulation port
package hep_pkg;
  `include "hep_defines.svh"

  typedef enum logic [1:0] {
    HEP_RD_NONE,
    HEP_RD_FM_DATA,
    HEP_RD_UART_DATA,
    HEP_RD_UART_STATUS
  } hep_rd_sel_t;

  typedef struct packed {
    logic [`HEP_PIN_W-1:0] sync1;
    logic [`HEP_PIN_W-1:0] sync2;
    logic [`HEP_PIN_W-1:0] sync3;
    logic [`HEP_PIN_W-1:0] filt;
    logic [`HEP_DATA_W-1:0] fm_readback;
    logic [`HEP_DATA_W-1:0] uart_data;
    logic uart_waiting;
    logic [`HEP_DATA_W-1:0] data_out;
    logic data_oe_n;
    logic fm_irq;
    logic uart_irq;
    logic pending;
    logic [`HEP_ENTRY_W-1:0] entry;
    logic entry_valid;
  } hep_state_t;
endpackage

// [hep_fifo.sv]
// first-in first-out store for captured host writes
`timescale 1ns/1ps
module hep_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 64
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } hep_fifo_state_t;

  hep_fifo_state_t st_reg;
  hep_fifo_state_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("hep_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1)
  begin : g_bad_width
    $error("hep_fifo: WIDTH must be at least 1");
  end

  assign full = (st_reg.count == (AW + 1)'(DEPTH));
  assign empty = (st_reg.count == '0);
  assign level = st_reg.count;
  assign head = mem[st_reg.rd_ptr];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb
  begin
    st_next = st_reg;
    if (do_push)
    begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // storage needs no reset; count guards every read of it
  always_ff @(posedge clk_sys)
  begin
    if (do_push)
    begin
      mem[st_reg.wr_ptr] <= push_data;
    end
  end
endmodule

// [hep_host_port.sv]
// parallel host port emulating an fm register set and a midi uart register set
`timescale 1ns/1ps
`include "hep_defines.svh"
module hep_host_port
  import hep_pkg::*;
#(
  parameter int FIFO_DEPTH = `HEP_FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic fm_set_select_n,
  input wire logic uart_set_select_n,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic [`HEP_ADDR_W-1:0] host_reg_addr,
  input wire logic [`HEP_DATA_W-1:0] host_data_bus_in,
  output logic [`HEP_DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  output logic fm_set_host_irq,
  output logic uart_set_host_irq,
  input wire logic mcu_fm_readback_wr,
  input wire logic mcu_uart_data_wr,
  input wire logic [`HEP_DATA_W-1:0] mcu_wr_data,
  input wire logic mcu_fm_irq_req,
  input wire logic mcu_uart_irq_en,
  input wire logic mcu_fifo_pop,
  output logic [`HEP_ENTRY_W-1:0] mcu_fifo_entry,
  output logic mcu_fifo_entry_valid,
  output logic mcu_host_pending
);
  hep_state_t st_reg;
  hep_state_t st_next;
  logic [`HEP_PIN_W-1:0] pins_in;
  logic [`HEP_PIN_W-1:0] agree;
  logic [`HEP_PIN_W-1:0] filt_new;
  logic wr_release;
  logic rd_start;
  logic one_sel_old;
  logic one_sel_new;
  logic push;
  logic [`HEP_ENTRY_W-1:0] push_entry;
  logic pop;
  logic uart_data_read;
  hep_rd_sel_t rd_sel;
  logic [`HEP_ENTRY_W-1:0] fifo_head;
  logic fifo_full;
  logic fifo_empty;
  logic [`HEP_LEVEL_W-1:0] fifo_level;

  // the level output is sized from the documented depth
  if (FIFO_DEPTH != `HEP_FIFO_DEPTH)
  begin : g_bad_depth
    $error("hep_host_port: FIFO_DEPTH must be 64");
  end

  // which readback a host read addresses; unmapped reads get none
  function automatic hep_rd_sel_t read_target(input logic [`HEP_PIN_W-1:0] p);
    logic [`HEP_ADDR_W-1:0] a;
    hep_rd_sel_t sel;
    a = p[`HEP_PIN_ADDR_HI:`HEP_PIN_ADDR_LO];
    sel = HEP_RD_NONE;
    if (!p[`HEP_PIN_FM_SEL] && p[`HEP_PIN_UART_SEL])
    begin
      if (a == `HEP_FM_READBACK_OFS) sel = HEP_RD_FM_DATA;
    end
    else if (p[`HEP_PIN_FM_SEL] && !p[`HEP_PIN_UART_SEL])
    begin
      if (a == `HEP_MIDI_READBACK_DATA_OFS) sel = HEP_RD_UART_DATA;
      else if (a == `HEP_MIDI_PORT_STATUS_OFS) sel = HEP_RD_UART_STATUS;
    end
    return sel;
  endfunction

  assign pins_in = {fm_set_select_n, uart_set_select_n, host_write_strobe_n,
                    host_read_strobe_n, host_reg_addr, host_data_bus_in};

  // a bit moves only once the second and third stages agree
  assign agree = ~(st_reg.sync2 ^ st_reg.sync3);
  assign filt_new = (st_reg.sync2 & agree) | (st_reg.filt & ~agree);

  // both selects low is illegal from the host, so such accesses are ignored
  assign one_sel_old = st_reg.filt[`HEP_PIN_FM_SEL] ^ st_reg.filt[`HEP_PIN_UART_SEL];
  assign one_sel_new = filt_new[`HEP_PIN_FM_SEL] ^ filt_new[`HEP_PIN_UART_SEL];

  // capture at the strobe's trailing edge, where isa write data is surely valid
  assign wr_release = !st_reg.filt[`HEP_PIN_WR] && filt_new[`HEP_PIN_WR];
  assign push = wr_release && one_sel_old && !fifo_full;
  // set id is the first select's level: 0 when the fm set was selected
  assign push_entry = {st_reg.filt[`HEP_PIN_FM_SEL],
                       st_reg.filt[`HEP_PIN_ADDR_HI:`HEP_PIN_ADDR_LO],
                       st_reg.filt[`HEP_PIN_DATA_HI:`HEP_PIN_DATA_LO]};

  assign rd_start = st_reg.filt[`HEP_PIN_RD] && !filt_new[`HEP_PIN_RD];
  assign rd_sel = read_target(filt_new);
  assign uart_data_read = rd_start && (rd_sel == HEP_RD_UART_DATA);
  assign pop = mcu_fifo_pop && !fifo_empty;

  hep_fifo
  #(
    .WIDTH(`HEP_ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .push(push),
    .push_data(push_entry),
    .pop(pop),
    .head(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty),
    .level(fifo_level)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = pins_in;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.filt = filt_new;
    if (mcu_fm_readback_wr)
    begin
      st_next.fm_readback = mcu_wr_data;
    end
    if (mcu_uart_data_wr)
    begin
      st_next.uart_data = mcu_wr_data;
    end
    // a new byte in the same cycle as the host read keeps the flag set
    if (mcu_uart_data_wr)
    begin
      st_next.uart_waiting = 1'b1;
    end
    else if (uart_data_read)
    begin
      st_next.uart_waiting = 1'b0;
    end
    st_next.uart_irq = st_next.uart_waiting && mcu_uart_irq_en;
    st_next.fm_irq = mcu_fm_irq_req;
    // drive only while a read strobe and a single select are active
    st_next.data_oe_n = !(!filt_new[`HEP_PIN_RD] && one_sel_new);
    case (rd_sel)
      HEP_RD_FM_DATA: st_next.data_out = st_reg.fm_readback;
      HEP_RD_UART_DATA: st_next.data_out = st_reg.uart_data;
      HEP_RD_UART_STATUS: st_next.data_out = {!st_reg.uart_waiting, fifo_full,
                                              `HEP_STAT_UNUSED};
      default: st_next.data_out = `HEP_UNDEF_READ;
    endcase
    st_next.pending = !fifo_empty;
    st_next.entry_valid = pop;
    if (pop)
    begin
      st_next.entry = fifo_head;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
      st_reg.sync1 <= `HEP_PIN_IDLE;
      st_reg.sync2 <= `HEP_PIN_IDLE;
      st_reg.sync3 <= `HEP_PIN_IDLE;
      st_reg.filt <= `HEP_PIN_IDLE;
      st_reg.fm_readback <= `HEP_DATA_RESET;
      st_reg.uart_data <= `HEP_DATA_RESET;
      st_reg.data_out <= `HEP_DATA_RESET;
      st_reg.data_oe_n <= 1'b1;
      st_reg.entry <= `HEP_ENTRY_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign host_data_bus_out = st_reg.data_out;
  assign host_data_bus_oe_n = st_reg.data_oe_n;
  assign fm_set_host_irq = st_reg.fm_irq;
  assign uart_set_host_irq = st_reg.uart_irq;
  assign mcu_fifo_entry = st_reg.entry;
  assign mcu_fifo_entry_valid = st_reg.entry_valid;
  assign mcu_host_pending = st_reg.pending;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_write_pushes;
    wr_release && one_sel_old && !fifo_full |-> push &&
      push_entry[`HEP_ENT_SET_BIT] == !st_reg.filt[`HEP_PIN_UART_SEL];
  endproperty
  a_write_pushes: assert property (p_write_pushes)
    else $error("qualified host write was not pushed with its set id");

  property p_no_push_both_sel;
    !st_reg.filt[`HEP_PIN_FM_SEL] && !st_reg.filt[`HEP_PIN_UART_SEL] |-> !push;
  endproperty
  a_no_push_both_sel: assert property (p_no_push_both_sel)
    else $error("write pushed while both selects were low");

  property p_level_grows;
    push && !pop |=> fifo_level == $past(fifo_level) + 7'h01;
  endproperty
  a_level_grows: assert property (p_level_grows)
    else $error("fifo level did not grow by one on push");

  property p_full_drops;
    wr_release && one_sel_old && fifo_full && !pop |=> fifo_full && $stable(fifo_level);
  endproperty
  a_full_drops: assert property (p_full_drops)
    else $error("write to a full fifo changed its contents");

  property p_pending_follows;
    1'b1 |=> mcu_host_pending == !$past(fifo_empty);
  endproperty
  a_pending_follows: assert property (p_pending_follows)
    else $error("pending flag does not follow fifo occupancy");

  property p_pop_returns_head;
    pop |=> mcu_fifo_entry_valid && mcu_fifo_entry == $past(fifo_head);
  endproperty
  a_pop_returns_head: assert property (p_pop_returns_head)
    else $error("popped entry differs from fifo head");

  property p_fm_read;
    !filt_new[`HEP_PIN_RD] && rd_sel == HEP_RD_FM_DATA |=>
      host_data_bus_out == $past(st_reg.fm_readback) && !host_data_bus_oe_n;
  endproperty
  a_fm_read: assert property (p_fm_read)
    else $error("fm read did not return the readback byte");

  property p_uart_read;
    rd_sel == HEP_RD_UART_DATA |=> host_data_bus_out == $past(st_reg.uart_data);
  endproperty
  a_uart_read: assert property (p_uart_read)
    else $error("uart data read returned the wrong byte");

  property p_status_read;
    rd_sel == HEP_RD_UART_STATUS |=>
      host_data_bus_out[`HEP_STAT_WAIT_BIT] == !$past(st_reg.uart_waiting) &&
      host_data_bus_out[`HEP_STAT_FULL_BIT] == $past(fifo_full) &&
      host_data_bus_out[5:0] == `HEP_STAT_UNUSED;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status byte does not match waiting and full state");

  property p_uart_irq_raise;
    mcu_uart_data_wr && mcu_uart_irq_en |=> uart_set_host_irq && st_reg.uart_waiting;
  endproperty
  a_uart_irq_raise: assert property (p_uart_irq_raise)
    else $error("uart interrupt not raised for a new byte");

  property p_read_clears;
    uart_data_read && !mcu_uart_data_wr |=> !st_reg.uart_waiting && !uart_set_host_irq;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("host data read did not clear waiting and interrupt");

  property p_bus_released;
    filt_new[`HEP_PIN_RD] |=> host_data_bus_oe_n;
  endproperty
  a_bus_released: assert property (p_bus_released)
    else $error("data bus driven without a read strobe");
endmodule

// [hep_host_model.sv]
// host bus master model driving the two emulated register sets
`timescale 1ns/1ps
module hep_host_model
(
  input wire logic clk_sys,
  output logic fm_set_select_n,
  output logic uart_set_select_n,
  output logic host_write_strobe_n,
  output logic host_read_strobe_n,
  output logic [2:0] host_reg_addr,
  output logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_n
);
  logic drv = 1'b0;
  logic [7:0] hval = 8'h00;
  logic [7:0] last = 8'h00;

  // released lines toggle so a stale byte never looks valid
  assign host_data_bus_in = drv ? hval : (!host_data_bus_oe_n ? host_data_bus_out : ~last);

  always @(posedge clk_sys)
    last <= host_data_bus_in;

  initial
  begin
    fm_set_select_n = 1'b1;
    uart_set_select_n = 1'b1;
    host_write_strobe_n = 1'b1;
    host_read_strobe_n = 1'b1;
    host_reg_addr = 3'h0;
  end

  // select, address and data set with the strobe and held six cycles past its release
  task automatic access(input logic [1:0] sel, input logic wr, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    {uart_set_select_n, fm_set_select_n} <= sel;
    host_reg_addr <= a;
    hval <= d;
    drv <= wr;
    host_write_strobe_n <= !wr;
    host_read_strobe_n <= wr;
    repeat (7) @(posedge clk_sys);
    // sample mid-cycle what the pins show, so a missing drive enable is seen
    @(negedge clk_sys);
    q = host_data_bus_in;
    @(posedge clk_sys);
    host_write_strobe_n <= 1'b1;
    host_read_strobe_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    {uart_set_select_n, fm_set_select_n} <= 2'b11;
    drv <= 1'b0;
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the host emulation port
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] sel_fm = 2'b10;
  localparam logic [1:0] sel_uart = 2'b01;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic fm_set_select_n, uart_set_select_n, host_write_strobe_n, host_read_strobe_n;
  logic [2:0] host_reg_addr;
  logic [7:0] host_data_bus_in, host_data_bus_out, mcu_wr_data;
  logic host_data_bus_oe_n, fm_set_host_irq, uart_set_host_irq;
  logic mcu_fm_readback_wr, mcu_uart_data_wr, mcu_fm_irq_req, mcu_uart_irq_en;
  logic mcu_fifo_pop, mcu_fifo_entry_valid, mcu_host_pending;
  logic [11:0] mcu_fifo_entry;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] q;
  logic [11:0] e;
  logic v;

  always #2 clk_sys = ~clk_sys;

  hep_host_port #(.FIFO_DEPTH(64)) u_dut (.clk_sys, .reset_n, .fm_set_select_n,
    .uart_set_select_n, .host_write_strobe_n, .host_read_strobe_n, .host_reg_addr,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n, .fm_set_host_irq,
    .uart_set_host_irq, .mcu_fm_readback_wr, .mcu_uart_data_wr, .mcu_wr_data,
    .mcu_fm_irq_req, .mcu_uart_irq_en, .mcu_fifo_pop, .mcu_fifo_entry,
    .mcu_fifo_entry_valid, .mcu_host_pending);

  hep_host_model u_host (.clk_sys, .fm_set_select_n, .uart_set_select_n,
    .host_write_strobe_n, .host_read_strobe_n, .host_reg_addr, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe_n);

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] x);
    u_host.access(s, 1'b0, a, 8'h00, q);
    chk({4'h0, q}, {4'h0, x});
  endtask

  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    u_host.access(s, 1'b1, a, d, q);
  endtask

  task automatic mcu(input logic fm, input logic [7:0] d);
    @(posedge clk_sys);
    mcu_fm_readback_wr <= fm;
    mcu_uart_data_wr <= !fm;
    mcu_wr_data <= d;
    @(posedge clk_sys);
    mcu_fm_readback_wr <= 1'b0;
    mcu_uart_data_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // valid is searched for a few cycles since its exact edge is the design's choice
  task automatic pop();
    @(posedge clk_sys);
    mcu_fifo_pop <= 1'b1;
    @(posedge clk_sys);
    mcu_fifo_pop <= 1'b0;
    v = 1'b0;
    for (int k = 0; k < 4 && !v; k++)
    begin
      @(negedge clk_sys);
      v = (mcu_fifo_entry_valid === 1'b1);
    end
    e = mcu_fifo_entry;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    mcu_fm_readback_wr = 1'b0;
    mcu_uart_data_wr = 1'b0;
    mcu_wr_data = 8'h00;
    mcu_fm_irq_req = 1'b0;
    mcu_uart_irq_en = 1'b0;
    mcu_fifo_pop = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({8'h0, fm_set_host_irq, uart_set_host_irq, mcu_host_pending, host_data_bus_oe_n}, 12'h1);
    rd(sel_uart, 3'h1, 8'h80);
    rd(sel_fm, 3'h1, 8'h00);
    $display("test reset_status done");

    mcu(1'b1, 8'ha5);
    rd(sel_fm, 3'h0, 8'ha5);
    @(posedge clk_sys);
    mcu_fm_irq_req <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(12'(fm_set_host_irq), 12'h1);
    @(posedge clk_sys);
    mcu_fm_irq_req <= 1'b0;
    $display("test fm_readback done");

    mcu(1'b0, 8'h3c);
    @(negedge clk_sys);
    chk(12'(uart_set_host_irq), 12'h0);
    @(posedge clk_sys);
    mcu_uart_irq_en <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(12'(uart_set_host_irq), 12'h1);
    rd(sel_uart, 3'h1, 8'h00);
    rd(sel_uart, 3'h0, 8'h3c);
    @(negedge clk_sys);
    chk(12'(uart_set_host_irq), 12'h0);
    rd(sel_uart, 3'h1, 8'h80);
    mcu(1'b0, 8'h5a);
    @(negedge clk_sys);
    chk(12'(uart_set_host_irq), 12'h1);
    rd(sel_uart, 3'h0, 8'h5a);
    @(negedge clk_sys);
    chk(12'(uart_set_host_irq), 12'h0);
    $display("test uart_data done");

    wr(sel_fm, 3'h3, 8'h11);
    wr(sel_uart, 3'h5, 8'h22);
    @(negedge clk_sys);
    chk(12'(mcu_host_pending), 12'h1);
    pop();
    chk(e, 12'h311);
    pop();
    chk(e, 12'hd22);
    // both selects, then none: neither may reach the store
    wr(2'b00, 3'h1, 8'h55);
    wr(2'b11, 3'h1, 8'h66);
    @(negedge clk_sys);
    chk(12'(mcu_host_pending), 12'h0);
    $display("test host_writes done");

    for (int i = 0; i < 65; i++)
      wr(i[0] ? sel_uart : sel_fm, 3'(i >> 3), 8'(i * 3));
    rd(sel_uart, 3'h1, 8'hc0);
    for (int i = 0; i < 64; i++)
    begin
      pop();
      chk(e, {i[0], 3'(i >> 3), 8'(i * 3)});
    end
    pop();
    chk(12'(v), 12'h0);
    @(negedge clk_sys);
    chk(12'(mcu_host_pending), 12'h0);
    rd(sel_uart, 3'h1, 8'h80);
    $display("test fifo_fill done");
    finish_test();
  end
endmodule
